/* hdl/vmc_pkg.sv */
// vmc_pkg: constants for the 8086-emulation mode controller
// assumes a 32-bit flags word laid out as the core's flags register
package vmc_pkg;
  localparam int FLAGS_W        = 32;
  localparam int VM_BIT         = 17;          // upper word, only 32-bit images carry it
  localparam int NT_BIT         = 14;
  localparam int IO_PRIVILEGE_FIELD_LO        = 12;
  localparam int IO_PRIVILEGE_FIELD_HI        = 13;
  localparam int UPPER_LO       = 16;
  localparam logic [1:0] EMU_CPL = 2'h3;
  localparam int SEG_W          = 16;
  localparam int LIN_W          = 32;
  localparam int EMU_LIN_W      = 21;          // 1 MByte plus 64 KBytes fits in 21 bits
  localparam logic [31:0] EMU_LIN_TOP = 32'h0010ffef;
  localparam logic [31:0] FLAGS_RESET = 32'h00000002;
  localparam logic [1:0]  CPL_RESET   = 2'h0;
  typedef enum logic [1:0] {VMC_IDLE, VMC_FLAGS, VMC_SEGS} vmc_state_e;
endpackage

/* hdl/vmc_ctrl.sv */
// vmc_ctrl: virtual-machine flag keeper, segment base former and emulation address guard
// assumes one core clock, one-cycle event pulses from the sequencer, sync active-high reset
// What this block does
// - emulation mode runs exactly while the virtual-machine flag is set
// - flag only becomes set on task switch or interrupt return
// - flags pop and direct flag writes never change the virtual-machine flag
// - segment loads pick 8086 or protected base formation from the flag
// - decoder gets flag to mark unsupported and I/O-privilege-sensitive instructions
// - task switch from a 16-bit image clears the virtual-machine flag
// - task switch updates the flag before any segment register is loaded
// - flag set after switch: segments loaded with 8086-style base formation
// - switch to task whose stored image has flag set enters emulation
// - non-nested interrupt return with flag set in popped image enters emulation
// - nested-task interrupt return to an emulation task enters emulation
// - emulation runs at current privilege level 3
// - 21-bit emulation addresses widen to 32-bit before paging
// - emulation addresses stay within first 1 MByte plus 64 KBytes once the segment reload after the flag sets has finished
// - emulation accesses to supervisor pages are denied
// - switch to 16-bit or flag-clear image leaves emulation with protected bases
// - servicing an interrupt or exception raised in emulation leaves emulation when no reload is under way and no switch or return starts in the same cycle
// - I/O privilege field sits at bits 12 and 13 of flags word
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
module vmc_ctrl
  import vmc_pkg::*;
#(
  parameter int NSEG = 6
)(
  input  wire logic               core_clk,            // core clock
  input  wire logic               rst,                 // sync reset, active high
  // task switch request
  input  wire logic               ts_start,            // pulse: begin task switch
  input  wire logic               ts_image_32,         // new image is 32-bit
  input  wire logic [FLAGS_W-1:0] ts_flags_image,      // flags from new task image
  input  wire logic [SEG_W-1:0]   ts_seg_sel [NSEG],   // segment images from new task
  input  wire logic [1:0]         ts_cpl,              // privilege of new task when protected
  // interrupt return
  input  wire logic               interrupt_return_instr_start,          // pulse: interrupt return
  input  wire logic [FLAGS_W-1:0] interrupt_return_instr_flags_image,    // flags popped from stack
  input  wire logic               interrupt_return_instr_target_emu,     // nested return target is emulation task
  input  wire logic [SEG_W-1:0]   interrupt_return_instr_seg_sel [NSEG], // segment images popped
  input  wire logic [1:0]         interrupt_return_instr_cpl,            // privilege when returning protected
  // live flag writes and event service
  input  wire logic               flags_wr,            // pulse: flags pop or direct write
  input  wire logic [FLAGS_W-1:0] flags_wr_data,       // value written
  input  wire logic               event_service,       // pulse: interrupt or exception taken
  // single segment register load
  input  wire logic               seg_load,            // pulse: load one segment register
  input  wire logic [2:0]         seg_load_idx,        // which segment register
  input  wire logic [SEG_W-1:0]   seg_load_sel,        // selector or paragraph value
  input  wire logic [LIN_W-1:0]   seg_desc_base,       // descriptor base for protected mode
  // address path
  input  wire logic [2:0]         addr_seg_idx,        // segment used for access
  input  wire logic [SEG_W-1:0]   addr_offset,         // effective offset
  input  wire logic               addr_valid,          // access requested
  input  wire logic               page_user,           // page entry user/supervisor bit
  output logic [FLAGS_W-1:0]      flags_word,          // live flags word
  output logic                    virtual_machine_flag,// emulation mode active
  output logic [1:0]              current_privilege_level, // current privilege
  output logic [1:0]              io_privilege_field,  // I/O privilege field
  output logic                    dec_emu_mode,        // decoder emulation qualifier
  output logic                    dec_io_privilege_field_sensitive,  // I/O-sensitive instructions trap
  output logic                    seg_busy,            // segment reload in progress
  output logic [LIN_W-1:0]        lin_addr,            // linear address to paging
  output logic                    lin_valid,           // linear address valid
  output logic                    access_denied        // emulation hit supervisor page
);
  vmc_state_e         st_q, st_d;
  logic [FLAGS_W-1:0] flags_q, flags_d;
  logic [1:0]         cpl_q, cpl_d, new_cpl_q, new_cpl_d;
  logic [SEG_W-1:0]   new_sel_q [NSEG];
  logic [SEG_W-1:0]   new_sel_d [NSEG];
  logic [LIN_W-1:0]   base_q [NSEG];
  logic [LIN_W-1:0]   base_d [NSEG];
  logic [FLAGS_W-1:0] pend_flags_q, pend_flags_d;
  logic [LIN_W-1:0]   lin_q, lin_d;
  logic               lin_v_q, lin_v_d, deny_q, deny_d;
  logic               dec_emu_q, dec_io_q;
  logic               busy_q;
  logic [EMU_LIN_W-1:0] emu_sum;

  // paragraph shift: the seg*16 base as an 8086 would form it
  function automatic logic [LIN_W-1:0] emu_base(input logic [SEG_W-1:0] sel);
    emu_base = {12'h000, sel, 4'h0};
  endfunction

  always_comb
  begin
    st_d         = st_q;
    flags_d      = flags_q;
    cpl_d        = cpl_q;
    new_cpl_d    = new_cpl_q;
    pend_flags_d = pend_flags_q;
    new_sel_d    = new_sel_q;
    base_d       = base_q;
    unique case (st_q)
      VMC_IDLE:
      begin
        if (ts_start)
        begin
          pend_flags_d = ts_flags_image;
          if (!ts_image_32)
            pend_flags_d[FLAGS_W-1:UPPER_LO] = '0;
          new_sel_d = ts_seg_sel;
          new_cpl_d = ts_cpl;
          st_d      = VMC_FLAGS;
        end
        else if (interrupt_return_instr_start)
        begin
          pend_flags_d = interrupt_return_instr_flags_image;
          if (flags_q[NT_BIT])
            pend_flags_d[VM_BIT] = interrupt_return_instr_target_emu;
          new_sel_d = interrupt_return_instr_seg_sel;
          new_cpl_d = interrupt_return_instr_cpl;
          st_d      = VMC_FLAGS;
        end
        else if (event_service && flags_q[VM_BIT])
        begin
          flags_d[VM_BIT] = 1'b0;
          cpl_d           = CPL_RESET;
          for (int i = 0; i < NSEG; i++)
            base_d[i] = '0;
        end
        else if (flags_wr)
        begin
          flags_d         = flags_wr_data;
          flags_d[VM_BIT] = flags_q[VM_BIT];
        end
        else if (seg_load && int'(seg_load_idx) < NSEG)
          base_d[seg_load_idx] = flags_q[VM_BIT] ? emu_base(seg_load_sel) : seg_desc_base;
      end
      VMC_FLAGS:
      begin
        // flag lands one cycle before any segment base is formed
        flags_d = pend_flags_q;
        cpl_d   = pend_flags_q[VM_BIT] ? EMU_CPL : new_cpl_q;
        st_d    = VMC_SEGS;
      end
      VMC_SEGS:
      begin
        // protected bases come from the sequencer's descriptor fetch on seg_desc_base
        for (int i = 0; i < NSEG; i++)
          base_d[i] = flags_q[VM_BIT] ? emu_base(new_sel_q[i]) : seg_desc_base;
        st_d = VMC_IDLE;
      end
      default:
        st_d = VMC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st_q         <= VMC_IDLE;
      flags_q      <= FLAGS_RESET;
      cpl_q        <= CPL_RESET;
      new_cpl_q    <= CPL_RESET;
      pend_flags_q <= FLAGS_RESET;
      for (int i = 0; i < NSEG; i++)
      begin
        new_sel_q[i] <= '0;
        base_q[i]    <= '0;
      end
    end
    else
    begin
      st_q         <= st_d;
      flags_q      <= flags_d;
      cpl_q        <= cpl_d;
      new_cpl_q    <= new_cpl_d;
      pend_flags_q <= pend_flags_d;
      new_sel_q    <= new_sel_d;
      base_q       <= base_d;
    end
  end

  // address path: 21-bit sum caps reach at 10ffefh without 1 MByte wrap
  always_comb
  begin
    emu_sum = base_q[addr_seg_idx][EMU_LIN_W-1:0] + {5'h00, addr_offset};
    lin_v_d = addr_valid && (int'(addr_seg_idx) < NSEG);
    deny_d  = 1'b0;
    if (flags_q[VM_BIT])
    begin
      lin_d  = {{(LIN_W-EMU_LIN_W){1'b0}}, emu_sum};
      deny_d = lin_v_d && !page_user;
    end
    else
      lin_d = base_q[addr_seg_idx] + {{(LIN_W-SEG_W){1'b0}}, addr_offset};
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      lin_q     <= '0;
      lin_v_q   <= 1'b0;
      deny_q    <= 1'b0;
      dec_emu_q <= 1'b0;
      dec_io_q  <= 1'b0;
      busy_q    <= 1'b0;
    end
    else
    begin
      lin_q     <= lin_d;
      lin_v_q   <= lin_v_d;
      deny_q    <= deny_d;
      dec_emu_q <= flags_d[VM_BIT];
      dec_io_q  <= flags_d[VM_BIT] && (flags_d[IO_PRIVILEGE_FIELD_HI:IO_PRIVILEGE_FIELD_LO] != EMU_CPL);
      // registered so the busy output comes straight from a flop, same timing as the state
      busy_q    <= (st_d != VMC_IDLE);
    end
  end

  assign flags_word              = flags_q;
  assign virtual_machine_flag    = flags_q[VM_BIT];
  assign current_privilege_level = cpl_q;
  assign io_privilege_field      = flags_q[IO_PRIVILEGE_FIELD_HI:IO_PRIVILEGE_FIELD_LO];
  assign dec_emu_mode            = dec_emu_q;
  assign dec_io_privilege_field_sensitive      = dec_io_q;
  assign seg_busy                = busy_q;
  assign lin_addr                = lin_q;
  assign lin_valid               = lin_v_q;
  assign access_denied           = deny_q;
endmodule

/* testbench/vmc_ctrl_asserts.sv */
// vmc_ctrl_asserts: port-level checks of the emulation mode controller
// assumes it is bound onto vmc_ctrl, one clock, sync active-high reset
`timescale 1ns/1ns
module vmc_ctrl_asserts
  import vmc_pkg::*;
#(
  parameter int NSEG = 6
)(
  input wire logic               core_clk,                // clock
  input wire logic               rst,                     // reset
  input wire logic               ts_start,                // switch pulse
  input wire logic               ts_image_32,             // image width
  input wire logic [FLAGS_W-1:0] ts_flags_image,          // image flags
  input wire logic               interrupt_return_instr_start,              // return pulse
  input wire logic               flags_wr,                // live write
  input wire logic               event_service,           // event taken
  input wire logic [2:0]         addr_seg_idx,            // access segment
  input wire logic               addr_valid,              // access strobe
  input wire logic               page_user,               // user page
  input wire logic [FLAGS_W-1:0] flags_word,              // live flags
  input wire logic               virtual_machine_flag,    // mode
  input wire logic [1:0]         current_privilege_level, // privilege
  input wire logic [1:0]         io_privilege_field,      // io field
  input wire logic               dec_emu_mode,            // decoder mode
  input wire logic               dec_io_privilege_field_sensitive,      // decoder trap
  input wire logic               seg_busy,                // reload busy
  input wire logic [LIN_W-1:0]   lin_addr,                // linear address
  input wire logic               lin_valid,               // address valid
  input wire logic               access_denied            // denied
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic sw_go;
  logic acc_emu;
  assign sw_go = ts_start && !seg_busy;
  assign acc_emu = addr_valid && virtual_machine_flag && !seg_busy && addr_seg_idx < 3'(NSEG);
  // flags first, then bases, busy across both
  sequence s_reload;
    seg_busy [*2] ##1 !seg_busy;
  endsequence
  AST_MODE: assert property (virtual_machine_flag == flags_word[VM_BIT] && dec_emu_mode == virtual_machine_flag)
    else $error("mode flag mismatch");
  AST_DEC_IO: assert property (io_privilege_field == flags_word[IO_PRIVILEGE_FIELD_HI:IO_PRIVILEGE_FIELD_LO] && dec_io_privilege_field_sensitive == (virtual_machine_flag && io_privilege_field != 2'h3))
    else $error("io field or decoder trap wrong");
  AST_CPL_EMU: assert property (virtual_machine_flag |-> current_privilege_level == EMU_CPL)
    else $error("emulation privilege not 3");
  AST_TS_BUSY: assert property (sw_go |=> s_reload)
    else $error("switch sequence length wrong");
  AST_TS_VM: assert property (sw_go |-> ##2 virtual_machine_flag == $past(ts_image_32 && ts_flags_image[VM_BIT], 2))
    else $error("switch mode flag wrong");
  AST_VM_SRC: assert property ($rose(virtual_machine_flag) |-> $past(ts_start || interrupt_return_instr_start, 2))
    else $error("mode flag set without switch or return");
  AST_FLAGS_KEEP: assert property (flags_wr && !ts_start && !interrupt_return_instr_start && !event_service && !seg_busy |=> $stable(virtual_machine_flag))
    else $error("live write moved mode flag");
  AST_EVENT: assert property (event_service && virtual_machine_flag && !ts_start && !interrupt_return_instr_start && !seg_busy |-> ##[1:2] (!virtual_machine_flag && current_privilege_level == 2'h0))
    else $error("event did not leave emulation");
  AST_LIN: assert property (acc_emu |=> lin_valid && lin_addr <= EMU_LIN_TOP)
    else $error("emulation address out of range");
  AST_DENY: assert property (acc_emu |=> access_denied == $past(!page_user))
    else $error("supervisor page decision wrong");
endmodule
bind vmc_ctrl vmc_ctrl_asserts #(.NSEG(NSEG)) u_vmc_ctrl_asserts (.core_clk, .rst, .ts_start, .ts_image_32,
  .ts_flags_image, .interrupt_return_instr_start, .flags_wr, .event_service, .addr_seg_idx, .addr_valid, .page_user, .flags_word,
  .virtual_machine_flag, .current_privilege_level, .io_privilege_field, .dec_emu_mode, .dec_io_privilege_field_sensitive,
  .seg_busy, .lin_addr, .lin_valid, .access_denied);

/* testbench/vmc_ctrl_tb.sv */
// vmc_ctrl_tb: random switches, returns, writes, events and accesses
// assumes the checker is bound in; bench drives every input itself
`timescale 1ns/1ns
module vmc_ctrl_tb
  import vmc_pkg::*;
;
  logic core_clk = 0, rst = 1, ts_start = 0, ts_image_32 = 0, interrupt_return_instr_start = 0, interrupt_return_instr_target_emu = 0, e, nt;
  logic flags_wr = 0, event_service = 0, seg_load = 0, addr_valid = 0, page_user = 0;
  logic [1:0] ts_cpl = 0, interrupt_return_instr_cpl = 0, current_privilege_level, io_privilege_field;
  logic [2:0] seg_load_idx = 0, addr_seg_idx = 0;
  logic [15:0] seg_load_sel = 0, addr_offset = 0, sel [6] = '{default: 0};
  logic [31:0] ts_flags_image = 0, interrupt_return_instr_flags_image = 0, flags_wr_data = 0, seg_desc_base = 0;
  logic [31:0] flags_word, lin_addr, base [6];
  logic virtual_machine_flag, dec_emu_mode, dec_io_privilege_field_sensitive, seg_busy, lin_valid, access_denied;
  int err_count = 0, n_compared = 0, cyc = 0;
  vmc_ctrl #(.NSEG(6)) u_vmc_ctrl (.core_clk, .rst, .ts_start, .ts_image_32, .ts_flags_image, .ts_seg_sel(sel),
    .ts_cpl, .interrupt_return_instr_start, .interrupt_return_instr_flags_image, .interrupt_return_instr_target_emu, .interrupt_return_instr_seg_sel(sel), .interrupt_return_instr_cpl, .flags_wr,
    .flags_wr_data, .event_service, .seg_load, .seg_load_idx, .seg_load_sel, .seg_desc_base, .addr_seg_idx,
    .addr_offset, .addr_valid, .page_user, .flags_word, .virtual_machine_flag, .current_privilege_level,
    .io_privilege_field, .dec_emu_mode, .dec_io_privilege_field_sensitive, .seg_busy, .lin_addr, .lin_valid, .access_denied);
  initial forever #4 core_clk = ~core_clk;
  // a run needs about 1100 cycles
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] fbase(input logic vm, input logic [15:0] s);
    return vm ? {12'h0, s, 4'h0} : seg_desc_base;
  endfunction
  // one pulse; waits out the reload, but address results stand only one cycle
  task automatic op(input int k);
    @(posedge core_clk);
    case (k)
      0: ts_start <= 1;
      1: interrupt_return_instr_start <= 1;
      2: event_service <= 1;
      3: flags_wr <= 1;
      4: seg_load <= 1;
      default: addr_valid <= 1;
    endcase
    @(posedge core_clk);
    {ts_start, interrupt_return_instr_start, event_service, flags_wr, seg_load, addr_valid} <= 6'h0;
    if (k < 5) repeat (2) @(posedge core_clk);
    for (int j = 0; j < 8 && k < 5 && seg_busy !== 1'b0; j++) @(posedge core_clk);
    #1;
  endtask
  task automatic acc(input logic [2:0] i, input logic u);
    @(posedge core_clk);
    addr_seg_idx <= i;
    addr_offset <= 16'($urandom);
    page_user <= u;
    op(5);
    chk(lin_valid, i < 6);
    if (i < 6) chk(lin_addr, e ? {11'h0, base[i][20:0] + {5'h0, addr_offset}} : base[i] + {16'h0, addr_offset});
    if (i < 6) chk(access_denied, e && !u);
  endtask
  initial
  begin
    void'($urandom(32'h31b1bad3));
    repeat (3) @(posedge core_clk);
    rst <= 0;
    @(posedge core_clk);
    #1;
    chk(flags_word, FLAGS_RESET);
    for (int i = 0; i < 40; i++)
    begin
      @(posedge core_clk);
      ts_image_32 <= (i % 4 != 1);
      ts_flags_image <= $urandom & ~(32'h1 << VM_BIT) | (32'(i % 2) << VM_BIT);
      ts_cpl <= 2'($urandom);
      seg_desc_base <= $urandom;
      foreach (sel[j]) sel[j] <= 16'($urandom);
      op(0);
      e = ts_image_32 && ts_flags_image[VM_BIT];
      chk(virtual_machine_flag, e);
      chk(current_privilege_level, e ? EMU_CPL : ts_cpl);
      chk(io_privilege_field, ts_flags_image[IO_PRIVILEGE_FIELD_HI:IO_PRIVILEGE_FIELD_LO]);
      foreach (base[j]) base[j] = fbase(e, sel[j]);
      acc(3'($urandom % 7), 1'($urandom));
      @(posedge core_clk);
      flags_wr_data <= $urandom & ~(32'h3 << NT_BIT) | (32'(i / 8 % 2) << NT_BIT) | (32'(!e) << VM_BIT);
      seg_load_idx <= 3'(i % 6);
      seg_load_sel <= 16'($urandom);
      op(3);
      chk(virtual_machine_flag, e);
      chk(flags_word, flags_wr_data & ~(32'h1 << VM_BIT) | (32'(e) << VM_BIT));
      chk(dec_emu_mode, e);
      chk(dec_io_privilege_field_sensitive, e && flags_wr_data[IO_PRIVILEGE_FIELD_HI:IO_PRIVILEGE_FIELD_LO] != EMU_CPL);
      op(4);
      base[i % 6] = fbase(e, seg_load_sel);
      acc(3'(i % 6), 1'($urandom));
      if (e && i % 3 == 0) op(2);
      if (e && i % 3 == 0) chk({virtual_machine_flag, current_privilege_level}, 3'h0);
      nt = flags_word[NT_BIT];
      @(posedge core_clk);
      interrupt_return_instr_flags_image <= $urandom & ~(32'h1 << VM_BIT) | (32'(i / 2 % 2) << VM_BIT);
      interrupt_return_instr_target_emu <= 1'(i / 4 % 2);
      interrupt_return_instr_cpl <= 2'($urandom);
      op(1);
      chk(virtual_machine_flag, nt ? interrupt_return_instr_target_emu : interrupt_return_instr_flags_image[VM_BIT]);
      chk(virtual_machine_flag ? current_privilege_level : EMU_CPL, EMU_CPL);
      $display("test %0d done", i);
    end
    final_report();
  end
endmodule
